//--- verilog/io_port_pkg.sv
// Shared constants and carriers for the programmable I/O port block.
// Assumes a single 125 MHz clock and a byte-wide host register bus.
package io_port_pkg;
    localparam int NUM_PORTS  = 7;
    localparam int PORT_WIDTH = 8;
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_C = 2;
    localparam int IDX_D = 3;
    localparam int IDX_E = 4;
    localparam int IDX_F = 5;
    localparam int IDX_G = 6;
    localparam logic [7:0] PORT_D_MASK = 8'h0f;
    localparam logic [7:0] FULL_MASK   = 8'hff;

    // Register offsets inside a port's slot, address = port*8 + offset
    localparam logic [2:0] OFF_PIN_INPUT   = 3'h0;
    localparam logic [2:0] OFF_OUTPUT_VAL  = 3'h1;
    localparam logic [2:0] OFF_DIRECTION   = 3'h2;
    localparam logic [2:0] OFF_DRIVE_SEL   = 3'h3;
    localparam logic [2:0] OFF_OE_STATUS   = 3'h4;
    localparam logic [2:0] OFF_MACROCELL   = 3'h5;
    localparam logic [2:0] OFF_INPUT_MC    = 3'h6;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // Output mux source per pin
    typedef enum logic [1:0] {SRC_OUTPUT_VALUE, SRC_MACROCELL, SRC_EXT_SELECT} out_src_t;
    // Input macrocell mode per pin
    typedef enum logic [1:0] {IMC_DIRECT, IMC_REGISTER, IMC_LATCH} imc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] port;
        logic [2:0] offset;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] open_drain;
        logic [7:0] fast_slew;
    } pin_drive_t;
endpackage

//--- verilog/input_macrocell.sv
// One port's eight input macrocells: register, latch or direct pass.
// Assumes the gating product term is synchronous to clk.
`timescale 1ns/1ns
module input_macrocell
    import io_port_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              pin_in,
    input  wire logic [7:0]              gate_term,
    input  wire imc_mode_t [7:0]         mode,
    output logic [7:0]                   mc_out
);
    logic [7:0] held_q;

    // Storage is clocked by clk and loads only while the logic-array gate term is high
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            held_q <= RESET_BYTE;
        else
            for (int i = 0; i < 8; i++)
                if (mode[i] != IMC_DIRECT && gate_term[i])
                    held_q[i] <= pin_in[i];
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
            unique case (mode[i])
                IMC_DIRECT:   mc_out[i] = pin_in[i];
                IMC_REGISTER: mc_out[i] = held_q[i];
                IMC_LATCH:    mc_out[i] = gate_term[i] ? pin_in[i] : held_q[i];
                default:      mc_out[i] = pin_in[i];
            endcase
    end
endmodule // input_macrocell

//--- verilog/io_ports.sv
// Seven programmable I/O ports with host-visible port registers.
// Assumes host strobes are one-cycle pulses synchronous to clk.
// Contract
// - Seven ports; port D has four pins
// - Output mux: value, macrocell, or C selects
// - Readback returns exactly one selected source
// - Driver enable is term OR direction
// - Without term, direction alone drives enable
// - Configured pin serves only one function
// - A-C input macrocells: register, latch, direct
// - Macrocells gated by logic-array term
// - Pin-input read returns live pin levels
// - Output value ignored when array selects macrocell or C selects
// - Direction 1 output, 0 input, default input
// - Drive-select 1 means open drain on all ports but C
// - Otherwise drive-select 1 means fast slew
// - F carries D0-D7; G D8-D15 when wide
// - G is host I/O only in 8-bit
// - Port D inputs bypass input macrocells
// - Array outputs: group A, group B, selects
// - Enable status reports each pin's enable before open-drain gating
// - JTAG multiplexing only on port E
`timescale 1ns/1ns
module io_ports
    import io_port_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire host_req_t                 host_req,
    output logic [7:0]                     host_rdata,
    output logic                           host_rvalid,
    input  wire logic                      bus_16bit,
    input  wire logic                      jtag_enable,
    input  wire logic [3:0]                jtag_out,
    input  wire logic [3:0]                jtag_oe,
    input  wire logic [15:0]               data_bus_out,
    input  wire logic                      data_bus_oe,
    input  wire out_src_t [NUM_PORTS-1:0][7:0] out_sel,
    input  wire logic [NUM_PORTS-1:0][7:0] array_owned,
    input  wire logic [NUM_PORTS-1:0][7:0] oe_term,
    input  wire logic [NUM_PORTS-1:0][7:0] oe_term_defined,
    input  wire imc_mode_t [2:0][7:0]      imc_mode,
    input  wire logic [2:0][7:0]           imc_gate,
    input  wire logic [7:0]                group_a_macrocells,
    input  wire logic [7:0]                group_b_macrocells,
    input  wire logic [7:0]                external_select_outputs,
    input  wire logic [NUM_PORTS-1:0][7:0] pin_in,
    output logic [NUM_PORTS-1:0][7:0]      pin_out,
    output logic [NUM_PORTS-1:0][7:0]      pin_oe_n,
    output logic [NUM_PORTS-1:0][7:0]      pin_fast_slew,
    output logic [23:0]                    logic_input_bus,
    output logic [3:0]                     port_d_direct,
    output logic [15:0]                    data_bus_in,
    output logic [3:0]                     jtag_in
);
    logic [NUM_PORTS-1:0][7:0] output_value_q;
    logic [NUM_PORTS-1:0][7:0] direction_q;
    logic [NUM_PORTS-1:0][7:0] drive_select_q;
    logic [NUM_PORTS-1:0][7:0] out_d;
    logic [NUM_PORTS-1:0][7:0] oe_d;
    logic [2:0][7:0]           imc_out;
    logic [7:0]                rdata_d;

    function automatic logic [7:0] port_mask(input int p);
        return (p == IDX_D) ? PORT_D_MASK : FULL_MASK;
    endfunction

    // Port G is host I/O only with an 8-bit data bus; F never is
    function automatic logic host_io_ok(input int p, input logic wide);
        return (p != IDX_F) && !(p == IDX_G && wide);
    endfunction

    function automatic logic [7:0] macro_src(input int p, input logic [7:0] a,
                                             input logic [7:0] b, input logic [7:0] c);
        unique case (p)
            IDX_A:   return a;
            IDX_B:   return b;
            IDX_C:   return c;
            default: return RESET_BYTE;
        endcase
    endfunction

    // Host writes land at the end of the strobed cycle
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            output_value_q <= '0;
            direction_q    <= '0;
            drive_select_q <= '0;
        end
        else if (host_req.wr && host_req.port < 3'(NUM_PORTS)
                 && host_io_ok(int'(host_req.port), bus_16bit))
        begin
            unique case (host_req.offset)
                OFF_OUTPUT_VAL: output_value_q[host_req.port] <=
                    host_req.wdata & port_mask(int'(host_req.port));
                OFF_DIRECTION:  direction_q[host_req.port] <=
                    host_req.wdata & port_mask(int'(host_req.port));
                OFF_DRIVE_SEL:  drive_select_q[host_req.port] <=
                    host_req.wdata & port_mask(int'(host_req.port));
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_imc
            input_macrocell u_imc (
                .clk     (clk),
                .reset_n (reset_n),
                .pin_in  (pin_in[g]),
                .gate_term (imc_gate[g]),
                .mode    (imc_mode[g]),
                .mc_out  (imc_out[g])
            );
        end
    endgenerate

    // Pin mux and enable; one owner per pin
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
            for (int i = 0; i < 8; i++)
            begin
                out_d[p][i] = output_value_q[p][i];
                if (array_owned[p][i])
                begin
                    // Array ownership lets out_sel override the value register
                    unique case (out_sel[p][i])
                        SRC_MACROCELL:  out_d[p][i] = |(macro_src(p, group_a_macrocells,
                                            group_b_macrocells, 8'h00) & (8'h01 << i));
                        SRC_EXT_SELECT: out_d[p][i] = (p == IDX_C) ?
                                            external_select_outputs[i] : 1'b0;
                        default:        out_d[p][i] = output_value_q[p][i];
                    endcase
                end
                if (oe_term_defined[p][i] || array_owned[p][i])
                    oe_d[p][i] = oe_term[p][i] | direction_q[p][i];
                else
                    oe_d[p][i] = direction_q[p][i];
                if (!host_io_ok(p, bus_16bit))
                begin
                    // Data bus owns F always, G when wide
                    out_d[p][i] = (p == IDX_F) ? data_bus_out[i] : data_bus_out[8 + i];
                    oe_d[p][i]  = data_bus_oe;
                end
                if (p == IDX_E && i < 4 && jtag_enable)
                begin
                    out_d[p][i] = jtag_out[i];
                    oe_d[p][i]  = jtag_oe[i];
                end
                if ((port_mask(p) & (8'h01 << i)) == 8'h00)
                begin
                    out_d[p][i] = 1'b0;
                    oe_d[p][i]  = 1'b0;
                end
            end
    end

    // Open drain: drive only a low, float a high
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pin_out       <= '0;
            pin_oe_n      <= '1;
            pin_fast_slew <= '0;
        end
        else
            for (int p = 0; p < NUM_PORTS; p++)
                for (int i = 0; i < 8; i++)
                begin
                    pin_out[p][i] <= out_d[p][i];
                    if (p == IDX_C)
                    begin
                        pin_oe_n[p][i]      <= !oe_d[p][i];
                        pin_fast_slew[p][i] <= drive_select_q[p][i];
                    end
                    else
                    begin
                        pin_oe_n[p][i] <= !(oe_d[p][i] &&
                            !(drive_select_q[p][i] && out_d[p][i]));
                        pin_fast_slew[p][i] <= 1'b0;
                    end
                end
    end

    // Readback picks exactly one source by offset
    always_comb
    begin
        rdata_d = RESET_BYTE;
        if (host_req.port < 3'(NUM_PORTS))
        begin
            unique case (host_req.offset)
                OFF_PIN_INPUT:  rdata_d = pin_in[host_req.port];
                OFF_OUTPUT_VAL: rdata_d = output_value_q[host_req.port];
                OFF_DIRECTION:  rdata_d = direction_q[host_req.port];
                OFF_DRIVE_SEL:  rdata_d = drive_select_q[host_req.port];
                OFF_OE_STATUS:  rdata_d = oe_d[host_req.port];
                OFF_MACROCELL:  rdata_d = macro_src(int'(host_req.port),
                    group_a_macrocells, group_b_macrocells, external_select_outputs);
                OFF_INPUT_MC:   rdata_d = (host_req.port < 3'd3) ?
                    imc_out[host_req.port[1:0]] : RESET_BYTE;
                default:        rdata_d = RESET_BYTE;
            endcase
            rdata_d = rdata_d & port_mask(int'(host_req.port));
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            host_rdata  <= RESET_BYTE;
            host_rvalid <= 1'b0;
        end
        else
        begin
            host_rvalid <= host_req.rd;
            if (host_req.rd)
                host_rdata <= rdata_d;
        end
    end

    // Logic-array side inputs
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            logic_input_bus <= '0;
            port_d_direct   <= '0;
            data_bus_in     <= '0;
            jtag_in         <= '0;
        end
        else
        begin
            logic_input_bus <= {imc_out[2], imc_out[1], imc_out[0]};
            port_d_direct   <= pin_in[IDX_D][3:0];
            data_bus_in     <= {bus_16bit ? pin_in[IDX_G] : RESET_BYTE, pin_in[IDX_F]};
            jtag_in         <= jtag_enable ? pin_in[IDX_E][3:0] : 4'h0;
        end
    end
endmodule // io_ports

//--- testbench/io_ports_sva.sv
// Checker for the I/O port block: host timing and pin paths.
// Assumes it is bound to io_ports and sees only that module's ports.
`timescale 1ns/1ns
module io_ports_sva
    import io_port_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire host_req_t                     host_req,
    input  wire logic                          host_rvalid,
    input  wire logic                          bus_16bit,
    input  wire logic                          jtag_enable,
    input  wire logic [15:0]                   data_bus_out,
    input  wire logic                          data_bus_oe,
    input  wire out_src_t [NUM_PORTS-1:0][7:0] out_sel,
    input  wire logic [NUM_PORTS-1:0][7:0]     array_owned,
    input  wire logic [NUM_PORTS-1:0][7:0]     oe_term,
    input  wire logic [NUM_PORTS-1:0][7:0]     oe_term_defined,
    input  wire logic [7:0]                    group_a_macrocells,
    input  wire logic [7:0]                    external_select_outputs,
    input  wire logic [NUM_PORTS-1:0][7:0]     pin_in,
    input  wire logic [NUM_PORTS-1:0][7:0]     pin_out,
    input  wire logic [NUM_PORTS-1:0][7:0]     pin_oe_n,
    input  wire logic [3:0]                    port_d_direct,
    input  wire logic [3:0]                    jtag_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Only valid while no array term may override the direction bits
    sequence dir_wr_a;
        host_req.wr && host_req.port == 3'h0 && host_req.offset == OFF_DIRECTION
            && oe_term_defined[IDX_A] == 8'h00 && array_owned[IDX_A] == 8'h00;
    endsequence
    a_read_answer: assert property (host_req.rd |=> host_rvalid)
        else $error("read not answered");
    a_no_spurious_valid: assert property (!host_req.rd |=> !host_rvalid)
        else $error("valid without read");
    a_dir_drives_oe: assert property (dir_wr_a |-> ##2 pin_oe_n[IDX_A] == ~$past(host_req.wdata, 2))
        else $error("direction not on driver enable");
    a_reset_inputs: assert property (disable iff (1'b0) !reset_n |=> &pin_oe_n)
        else $error("pins not inputs in reset");
    a_term_enables: assert property (oe_term_defined[IDX_A][0] && oe_term[IDX_A][0] |=> !pin_oe_n[IDX_A][0])
        else $error("enable term ignored");
    a_group_a_out: assert property (array_owned[IDX_A][0] && out_sel[IDX_A][0] == SRC_MACROCELL
        |=> pin_out[IDX_A][0] == $past(group_a_macrocells[0]))
        else $error("macrocell not on pin");
    a_ext_select_c: assert property (array_owned[IDX_C][3] && out_sel[IDX_C][3] == SRC_EXT_SELECT
        |=> pin_out[IDX_C][3] == $past(external_select_outputs[3]))
        else $error("select not on pin");
    a_port_f_bus: assert property (data_bus_oe |=> pin_out[IDX_F] == $past(data_bus_out[7:0]))
        else $error("low data byte not on port F");
    a_port_g_bus: assert property (bus_16bit && data_bus_oe |=> pin_out[IDX_G] == $past(data_bus_out[15:8]))
        else $error("high data byte not on port G");
    a_port_d_direct: assert property (1'b1 |=> port_d_direct == $past(pin_in[IDX_D][3:0]))
        else $error("port D input path wrong");
    a_jtag_in: assert property (jtag_enable |=> jtag_in == $past(pin_in[IDX_E][3:0]))
        else $error("jtag input path wrong");
endmodule // io_ports_sva
bind io_ports io_ports_sva u_sva (.clk, .reset_n, .host_req, .host_rvalid, .bus_16bit, .jtag_enable,
    .data_bus_out, .data_bus_oe, .out_sel, .array_owned, .oe_term, .oe_term_defined,
    .group_a_macrocells, .external_select_outputs, .pin_in, .pin_out, .pin_oe_n,
    .port_d_direct, .jtag_in);

//--- testbench/host_model.sv
// Host processor model: byte reads and writes on the register strobes.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ns
module host_model
    import io_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_rvalid,
    output host_req_t       host_req
);
    initial host_req = '0;
    task automatic wr(input logic [2:0] p, input logic [2:0] o, input logic [7:0] d);
        @(negedge clk);
        host_req = '{wr: 1'b1, rd: 1'b0, port: p, offset: o, wdata: d};
        @(negedge clk);
        // Released lines flip so stale values never look valid
        host_req = '{wr: 1'b0, rd: 1'b0, port: ~p, offset: ~o, wdata: ~d};
    endtask
    task automatic rd(input logic [2:0] p, input logic [2:0] o, output logic [7:0] d,
                      output logic ok);
        @(negedge clk);
        host_req = '{wr: 1'b0, rd: 1'b1, port: p, offset: o, wdata: host_req.wdata};
        @(negedge clk);
        ok = host_rvalid;
        d = host_rdata;
        host_req.rd = 1'b0;
    endtask
endmodule // host_model

//--- testbench/tb_top.sv
// Self-checking bench for the I/O port block.
// Assumes pins have pull-ups; undriven pins read high.
`timescale 1ns/1ns
module tb_top
    import io_port_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, bus_16bit = 1'b0, jtag_enable = 1'b0, data_bus_oe = 1'b0;
    logic [3:0] jtag_out = 4'h0, jtag_oe = 4'h0, port_d_direct, jtag_in;
    logic [15:0] data_bus_out = 16'h0000, data_bus_in;
    out_src_t [NUM_PORTS-1:0][7:0] out_sel = '{default: SRC_OUTPUT_VALUE};
    logic [NUM_PORTS-1:0][7:0] array_owned = '0, oe_term = '0, oe_term_defined = '0;
    logic [NUM_PORTS-1:0][7:0] pin_in, pin_out, pin_oe_n, pin_fast_slew;
    imc_mode_t [2:0][7:0] imc_mode = '{default: IMC_DIRECT};
    logic [2:0][7:0] imc_gate = '0;
    logic [7:0] group_a_macrocells = 8'h00, group_b_macrocells = 8'h00;
    logic [7:0] external_select_outputs = 8'h00, host_rdata;
    logic [23:0] logic_input_bus;
    logic host_rvalid;
    host_req_t host_req;
    int errors = 0, n_tests = 0, cycles = 0;
    assign pin_in = (pin_out & ~pin_oe_n) | pin_oe_n;
    always #4 clk = ~clk;
    io_ports u_dut (.clk, .reset_n, .host_req, .host_rdata, .host_rvalid, .bus_16bit,
        .jtag_enable, .jtag_out, .jtag_oe, .data_bus_out, .data_bus_oe, .out_sel, .array_owned,
        .oe_term, .oe_term_defined, .imc_mode, .imc_gate, .group_a_macrocells,
        .group_b_macrocells, .external_select_outputs, .pin_in, .pin_out, .pin_oe_n,
        .pin_fast_slew, .logic_input_bus, .port_d_direct, .data_bus_in, .jtag_in);
    host_model u_host (.clk, .host_rdata, .host_rvalid, .host_req);
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [2:0] p, input logic [2:0] o, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_host.rd(p, o, d, ok);
        if (ok !== 1'b1) d = ~exp;
        chk(d, exp);
    endtask
    // Registered pins lag the register by one edge
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        for (int p = 0; p < 7; p++) for (int o = 1; o < 4; o++) rchk(3'(p), 3'(o), 8'h00);
        u_host.wr(3'h0, OFF_DIRECTION, 8'ha5); settle; chk(pin_oe_n[IDX_A], 8'h5a);
        rchk(3'h0, OFF_OE_STATUS, 8'ha5);
        rchk(3'h0, OFF_DIRECTION, 8'ha5);
        u_host.wr(3'h0, OFF_DIRECTION, 8'hff);
        u_host.wr(3'h0, OFF_OUTPUT_VAL, 8'h3c); settle; chk(pin_out[IDX_A], 8'h3c);
        rchk(3'h0, OFF_PIN_INPUT, 8'h3c);
        out_sel[IDX_A][0] = SRC_MACROCELL; array_owned[IDX_A][0] = 1'b1;
        oe_term_defined[IDX_A][0] = 1'b1; oe_term[IDX_A][0] = 1'b1; group_a_macrocells = 8'h01;
        settle; chk(pin_out[IDX_A], 8'h3d);
        rchk(3'h0, OFF_OUTPUT_VAL, 8'h3c);
        out_sel[IDX_C][3] = SRC_EXT_SELECT; array_owned[IDX_C][3] = 1'b1;
        external_select_outputs = 8'h08;
        u_host.wr(3'h2, OFF_DIRECTION, 8'hff); settle; chk(pin_out[IDX_C], 8'h08);
        u_host.wr(3'h3, OFF_DIRECTION, 8'hff); rchk(3'h3, OFF_DIRECTION, 8'h0f);
        u_host.wr(3'h5, OFF_DIRECTION, 8'hff); rchk(3'h5, OFF_DIRECTION, 8'h00);
        data_bus_out = 16'h5aa5; data_bus_oe = 1'b1;
        settle; chk(pin_out[IDX_F], 8'ha5);
        bus_16bit = 1'b1; settle; chk(pin_out[IDX_G], 8'h5a);
        u_host.wr(3'h6, OFF_DIRECTION, 8'hff);
        bus_16bit = 1'b0; data_bus_oe = 1'b0; rchk(3'h6, OFF_DIRECTION, 8'h00);
        u_host.wr(3'h6, OFF_DIRECTION, 8'hff); rchk(3'h6, OFF_DIRECTION, 8'hff);
        u_host.wr(3'h2, OFF_DRIVE_SEL, 8'hff); u_host.wr(3'h1, OFF_DRIVE_SEL, 8'hff);
        u_host.wr(3'h1, OFF_DIRECTION, 8'hff); u_host.wr(3'h1, OFF_OUTPUT_VAL, 8'h0f); settle;
        chk(pin_fast_slew[IDX_C], 8'hff);
        chk(pin_fast_slew[IDX_B], 8'h00);
        chk(pin_oe_n[IDX_B], 8'h0f);
        rchk(3'h1, OFF_PIN_INPUT, 8'h0f);
        rchk(3'h1, OFF_DRIVE_SEL, 8'hff);
        jtag_enable = 1'b1; settle; chk({4'h0, jtag_in}, 8'h0f);
        chk(logic_input_bus[7:0], 8'h3d);
        chk(data_bus_in[7:0], 8'hff);
        imc_mode[IDX_B][0] = IMC_REGISTER; settle; rchk(3'h1, OFF_INPUT_MC, 8'h0e);
        imc_gate[IDX_B][0] = 1'b1; settle; rchk(3'h1, OFF_INPUT_MC, 8'h0f);
        rchk(3'h0, 3'h7, 8'h00);
        @(negedge clk) reset_n = 1'b0;
        @(negedge clk) reset_n = 1'b1;
        chk(pin_oe_n[IDX_A], 8'hff);
        rchk(3'h0, OFF_DIRECTION, 8'h00);
        print_verdict;
    end
endmodule // tb_top
